//--- pkg/rtc_consts.svh
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// register byte offsets
`define RTC_OFS_COUNT      5'h00
`define RTC_OFS_ALARM      5'h04
`define RTC_OFS_STATUS     5'h08
`define RTC_OFS_TRIM       5'h0c
`define RTC_OFS_CTRL       5'h10

// reset values
`define RTC_COUNT_RESET    32'h0000_0000
`define RTC_ALARM_RESET    32'h0000_0000
`define RTC_TRIM_RESET     32'h0000_7fff

// status register bits
`define RTC_ST_AL          0
`define RTC_ST_HZ          1
`define RTC_ST_ALE         2
`define RTC_ST_PEND        3

// trim register fields
`define RTC_TRIM_DIV_MSB   15
`define RTC_TRIM_DIV_LSB   0
`define RTC_TRIM_DEL_MSB   25
`define RTC_TRIM_DEL_LSB   16
`define RTC_TRIM_LOCK      31
`define RTC_TRIM_WMASK     32'h83ff_ffff

// control register bits
`define RTC_CTRL_SEL       0

// fast oscillator prescale: divide by 112
`define RTC_PRESCALE_LAST  7'h6f
// alarm and counter writes land on this many source clocks
`define RTC_WR_DELAY       2'h2

`endif

//--- pkg/rtc_pkg.sv
package rtc_pkg;

  // avalon-mm request from the processor side
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rtc_avs_req_s;

  // avalon-mm answer to the processor side
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } rtc_avs_rsp_s;

  // first-level interrupt sources and wake event
  typedef struct packed {
    logic alarm_irq_source;
    logic tick_irq_source;
    logic alarm_wake;
  } rtc_events_s;

endpackage : rtc_pkg

//--- hw/rtc_counter_alarm_trim.sv
`include "rtc_consts.svh"

module rtc_counter_alarm_trim #(
  parameter int TRIM_CYCLE_W = 10
) (
  // clock and resets
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                wdog_rst,
  // oscillator pins
  input  wire logic                osc_fast_in,
  input  wire logic                osc_slow_in,
  // register bus
  input  wire rtc_pkg::rtc_avs_req_s avs_req,
  output rtc_pkg::rtc_avs_rsp_s    avs_rsp,
  // interrupt controller and power manager
  output rtc_pkg::rtc_events_s     events
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0]  fast_sync_reg;
  logic [2:0]  slow_sync_reg;
  logic [6:0]  prescale_reg;
  logic        fast_pulse;
  logic        slow_pulse;
  logic        src_pulse;
  logic [15:0] div_cnt_reg;
  logic [9:0]  delete_left_reg;
  logic [TRIM_CYCLE_W-1:0] trim_cyc_reg;
  logic        tick;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] cnt_wval_reg;
  logic [1:0]  cnt_wait_reg;
  logic        cnt_pend_reg;
  logic        cnt_apply;
  logic [31:0] alarm_reg;
  logic [31:0] alarm_wval_reg;
  logic [1:0]  alarm_wait_reg;
  logic        alarm_pend_reg;
  logic        alarm_apply;
  logic [31:0] trim_reg;
  logic        sel_reg;
  logic        ale_reg;
  logic        al_reg;
  logic        hz_reg;
  logic        al_set;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        wr_fire;
  logic        rd_take;
  logic        soft_rst;

  // merge write data into an old value under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // next value of a two-source-clock write delay counter
  function automatic logic [1:0] wait_next(input logic [1:0] w, input logic pulse);
    return pulse ? w + 2'h1 : w;
  endfunction

  // watchdog reset acts like a hardware reset on all but trim, prescaler, sync flops and bus ack/read data
  assign soft_rst = !rst_n || wdog_rst;

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait state, then answer
  assign avs_rsp.waitrequest = (avs_req.read || avs_req.write) && !ack_reg;
  assign wr_fire             = avs_req.write && ack_reg;
  assign rd_take             = avs_req.read && !ack_reg;
  assign avs_rsp.readdata    = rdata_reg;

  // ack toggles so every request sees exactly one wait cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_req.read || avs_req.write) && !ack_reg;
    end
  end

  // read mux captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      case (avs_req.address)
        `RTC_OFS_COUNT:  rdata_reg <= cnt_reg;  // no write delay on reads
        `RTC_OFS_ALARM:  rdata_reg <= alarm_reg;
        `RTC_OFS_STATUS: rdata_reg <= {28'h000_0000, cnt_pend_reg || alarm_pend_reg, ale_reg, hz_reg, al_reg};
        `RTC_OFS_TRIM:   rdata_reg <= trim_reg;
        `RTC_OFS_CTRL:   rdata_reg <= {31'h0000_0000, sel_reg};
        default:         rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator pins: two sync flops, third flop only for edge detect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fast_sync_reg <= 3'h0;
      slow_sync_reg <= 3'h0;
    end else begin
      fast_sync_reg <= {fast_sync_reg[1:0], osc_fast_in};
      slow_sync_reg <= {slow_sync_reg[1:0], osc_slow_in};
    end
  end

  assign fast_pulse = fast_sync_reg[1] && !fast_sync_reg[2];
  assign slow_pulse = slow_sync_reg[1] && !slow_sync_reg[2];

  // fast oscillator divided by 112 to roughly 32.9 kHz
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale_reg <= 7'h00;
    end else if (fast_pulse) begin
      prescale_reg <= (prescale_reg == `RTC_PRESCALE_LAST) ? 7'h00 : prescale_reg + 7'h01;
    end
  end

  // source select, one pulse per source clock period
  assign src_pulse = sel_reg ? slow_pulse : (fast_pulse && prescale_reg == `RTC_PRESCALE_LAST);

  // source select register, cleared by either reset
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      sel_reg <= 1'b0;
    end else if (wr_fire && avs_req.address == `RTC_OFS_CTRL && avs_req.byteenable[0]) begin
      sel_reg <= avs_req.writedata[`RTC_CTRL_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trim divider: divider field +1 source clocks per tick, with deletion
  assign tick = src_pulse && delete_left_reg == 10'h000
                && div_cnt_reg == trim_reg[`RTC_TRIM_DIV_MSB:`RTC_TRIM_DIV_LSB];

  // divider counter; deleted source clocks do not advance it
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      div_cnt_reg <= 16'h0000;
    end else if (src_pulse && delete_left_reg == 10'h000) begin
      div_cnt_reg <= tick ? 16'h0000 : div_cnt_reg + 16'h0001;
    end
  end

  // trim cycle: every 2^TRIM_CYCLE_W ticks, swallow the delete count
  // gives sub-ppm resolution, far inside five seconds a month
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      trim_cyc_reg    <= '0;
      delete_left_reg <= 10'h000;
    end else begin
      if (tick) begin
        trim_cyc_reg <= trim_cyc_reg + 1'b1;
      end
      if (tick && trim_cyc_reg == '1) begin
        delete_left_reg <= trim_reg[`RTC_TRIM_DEL_MSB:`RTC_TRIM_DEL_LSB];
      end else if (src_pulse && delete_left_reg != 10'h000) begin
        delete_left_reg <= delete_left_reg - 10'h001;
      end
    end
  end

  // trim register: hardware reset only, frozen once locked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim_reg <= `RTC_TRIM_RESET;
    end else if (wr_fire && avs_req.address == `RTC_OFS_TRIM && !trim_reg[`RTC_TRIM_LOCK]) begin
      trim_reg <= be_merge(trim_reg, avs_req.writedata, avs_req.byteenable) & `RTC_TRIM_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter write staging: lands on the second source clock after store
  assign cnt_apply = cnt_pend_reg && src_pulse && wait_next(cnt_wait_reg, src_pulse) == `RTC_WR_DELAY;

  // a second store restarts the delay with the newest value
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      cnt_pend_reg <= 1'b0;
      cnt_wait_reg <= 2'h0;
      cnt_wval_reg <= `RTC_COUNT_RESET;
    end else if (wr_fire && avs_req.address == `RTC_OFS_COUNT) begin
      cnt_pend_reg <= 1'b1;
      cnt_wait_reg <= 2'h0;
      cnt_wval_reg <= be_merge(cnt_reg, avs_req.writedata, avs_req.byteenable);
    end else if (cnt_apply) begin
      cnt_pend_reg <= 1'b0;
    end else if (cnt_pend_reg) begin
      cnt_wait_reg <= wait_next(cnt_wait_reg, src_pulse);
    end
  end

  // free-running counter; no sleep or idle input touches it
  assign cnt_next = cnt_reg + 32'h0000_0001;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      cnt_reg <= `RTC_COUNT_RESET;
    end else if (cnt_apply) begin
      cnt_reg <= cnt_wval_reg;
    end else if (tick) begin
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm write staging, same two-source-clock delay
  assign alarm_apply = alarm_pend_reg && src_pulse && wait_next(alarm_wait_reg, src_pulse) == `RTC_WR_DELAY;

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      alarm_pend_reg <= 1'b0;
      alarm_wait_reg <= 2'h0;
      alarm_wval_reg <= `RTC_ALARM_RESET;
    end else if (wr_fire && avs_req.address == `RTC_OFS_ALARM) begin
      alarm_pend_reg <= 1'b1;
      alarm_wait_reg <= 2'h0;
      alarm_wval_reg <= be_merge(alarm_reg, avs_req.writedata, avs_req.byteenable);
    end else if (alarm_apply) begin
      alarm_pend_reg <= 1'b0;
    end else if (alarm_pend_reg) begin
      alarm_wait_reg <= wait_next(alarm_wait_reg, src_pulse);
    end
  end

  // alarm value register
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      alarm_reg <= `RTC_ALARM_RESET;
    end else if (alarm_apply) begin
      alarm_reg <= alarm_wval_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: compare the incremented count, flags are write-one-to-clear
  assign al_set = tick && !cnt_apply && ale_reg && cnt_next == alarm_reg;

  // alarm enable bit
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      ale_reg <= 1'b0;
    end else if (wr_fire && avs_req.address == `RTC_OFS_STATUS && avs_req.byteenable[0]) begin
      ale_reg <= avs_req.writedata[`RTC_ST_ALE];
    end
  end

  // set beats a clear arriving in the same cycle
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      al_reg <= 1'b0;
      hz_reg <= 1'b0;
    end else begin
      al_reg <= al_set || (al_reg && !(wr_fire && avs_req.address == `RTC_OFS_STATUS
                && avs_req.byteenable[0] && avs_req.writedata[`RTC_ST_AL]));
      hz_reg <= tick || (hz_reg && !(wr_fire && avs_req.address == `RTC_OFS_STATUS
                && avs_req.byteenable[0] && avs_req.writedata[`RTC_ST_HZ]));
    end
  end

  // flags straight to pending positions 31 and 30, alarm flag also to wake logic
  assign events.alarm_irq_source = al_reg;
  assign events.tick_irq_source  = hz_reg;
  assign events.alarm_wake       = al_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_CNT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    wdog_rst |=> cnt_reg == 32'h0000_0000)
    else $error("counter not cleared by watchdog reset");

  AST_CNT_INC: assert property (@(posedge clk) disable iff (soft_rst)
    tick && !cnt_apply |=> cnt_reg == $past(cnt_reg) + 32'h0000_0001)
    else $error("counter did not advance on tick");

  AST_CNT_HOLD: assert property (@(posedge clk) disable iff (soft_rst)
    !tick && !cnt_apply |=> $stable(cnt_reg))
    else $error("counter moved without tick or load");

  // a fresh store in the landing cycle keeps the stage busy on purpose
  AST_CNT_LOAD: assert property (@(posedge clk) disable iff (soft_rst)
    cnt_apply && !(wr_fire && avs_req.address == `RTC_OFS_COUNT)
    |=> cnt_reg == $past(cnt_wval_reg) && !cnt_pend_reg)
    else $error("staged counter value not loaded");

  AST_ALARM_SET: assert property (@(posedge clk) disable iff (soft_rst)
    tick && !cnt_apply && ale_reg && cnt_next == alarm_reg |=> al_reg && events.alarm_irq_source)
    else $error("alarm match flag not set");

  AST_ALARM_NOSET: assert property (@(posedge clk) disable iff (soft_rst)
    !al_reg && !(tick && ale_reg && cnt_next == alarm_reg) |=> !al_reg)
    else $error("alarm flag set without match");

  AST_TICK_FLAG: assert property (@(posedge clk) disable iff (soft_rst)
    tick |=> hz_reg && events.tick_irq_source)
    else $error("tick flag not set");

  AST_W1C: assert property (@(posedge clk) disable iff (soft_rst)
    wr_fire && avs_req.address == `RTC_OFS_STATUS && avs_req.byteenable[0]
    && avs_req.writedata[`RTC_ST_HZ] && !tick |=> !hz_reg)
    else $error("tick flag not cleared by write one");

  AST_TRIM_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    trim_reg[`RTC_TRIM_LOCK] |=> $stable(trim_reg))
    else $error("locked trim register changed");

  AST_TRIM_WDOG: assert property (@(posedge clk) disable iff (!rst_n)
    wdog_rst && !wr_fire |=> $stable(trim_reg))
    else $error("trim register disturbed by watchdog reset");

  AST_ALARM_DELAY: assert property (@(posedge clk) disable iff (soft_rst)
    wr_fire && avs_req.address == `RTC_OFS_ALARM && !alarm_apply |=> $stable(alarm_reg) && alarm_pend_reg)
    else $error("alarm write took effect without delay");

  AST_PRESCALE: assert property (@(posedge clk) disable iff (soft_rst)
    fast_pulse && prescale_reg != `RTC_PRESCALE_LAST |=> prescale_reg == $past(prescale_reg) + 7'h01)
    else $error("fast source not divided by 112");

  COV_ALARM: cover property (@(posedge clk) disable iff (soft_rst) al_set);
  COV_TICK_CLEAR: cover property (@(posedge clk) disable iff (soft_rst) hz_reg ##1 !hz_reg);
  COV_CNT_LOAD: cover property (@(posedge clk) disable iff (soft_rst) cnt_apply);
  COV_DELETE: cover property (@(posedge clk) disable iff (soft_rst) delete_left_reg != 10'h000);

endmodule // rtc_counter_alarm_trim

//--- bench/rtc_irq_ctrl_model.sv
// interrupt controller and power manager as seen from the unit
module rtc_irq_ctrl_model (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // sources from the unit
  input  wire rtc_pkg::rtc_events_s events,
  // software mask and results
  input  wire logic [31:0]          mask,
  output logic [31:0]               pending,
  output logic                      irq,
  output logic                      wake
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // single-source level inputs, so pending mirrors them one clock later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending <= 32'h0000_0000;
      wake    <= 1'b0;
    end else begin
      pending <= {events.alarm_irq_source, events.tick_irq_source, 30'h0000_0000};
      wake    <= events.alarm_wake;
    end
  end

  // masked pending raises the processor interrupt
  assign irq = |(pending & mask);
endmodule // rtc_irq_ctrl_model

//--- bench/tb_rtc_counter_alarm_trim.sv
`include "rtc_consts.svh"

module tb_rtc_counter_alarm_trim;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk;
  logic                  rst_n;
  logic                  wdog_rst;
  logic                  osc_fast_in;
  logic                  osc_slow_in;
  rtc_pkg::rtc_avs_req_s avs_req;
  rtc_pkg::rtc_avs_rsp_s avs_rsp;
  rtc_pkg::rtc_events_s  events;
  logic [31:0]           mask;
  logic [31:0]           pending;
  logic                  irq;
  logic                  wake;
  logic                  use_fast;
  logic                  ale;
  int                    err_count;
  int                    n_compared;
  int                    n;
  int                    tot;

  ////////////////////////////////////////////////////////////////////////////
  // short trim cycle keeps the delete check within a few ticks
  rtc_counter_alarm_trim #(.TRIM_CYCLE_W(2)) rtc_counter_alarm_trim_i (
    .clk(clk), .rst_n(rst_n), .wdog_rst(wdog_rst), .osc_fast_in(osc_fast_in),
    .osc_slow_in(osc_slow_in), .avs_req(avs_req), .avs_rsp(avs_rsp), .events(events));

  rtc_irq_ctrl_model rtc_irq_ctrl_model_i (
    .clk(clk), .rst_n(rst_n), .events(events), .mask(mask), .pending(pending), .irq(irq), .wake(wake));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rdat);
    int i;
    @(posedge clk);
    avs_req.read      <= !wr;
    avs_req.write     <= wr;
    avs_req.address   <= a;
    avs_req.writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_rsp.waitrequest === 1'b0) break;
    end
    rdat = avs_rsp.readdata;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
    if (i == 20) begin
      err_count++;
      $display("ERROR %0t: bus answer missing", $time);
      test_done();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] rdat;
    bus(1'b0, a, 32'h0000_0000, rdat);
    check(rdat, exp);
  endtask

  // one source clock edge on the selected oscillator pin
  task automatic pulse();
    @(posedge clk);
    if (use_fast) osc_fast_in <= 1'b1;
    else osc_slow_in <= 1'b1;
    repeat (3) @(posedge clk);
    osc_fast_in <= 1'b0;
    osc_slow_in <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // clears the tick flag, then counts source edges up to the next tick
  task automatic tick_wait(output int cnt);
    // enable sits at bit 2 and must be rewritten, bit 1 clears the tick flag
    wr(`RTC_OFS_STATUS, {29'h0000_0000, ale, 2'h2});
    for (cnt = 1; cnt <= 300; cnt++) begin
      pulse();
      if (events.tick_irq_source === 1'b1) break;
    end
    if (cnt > 300) begin
      err_count++;
      $display("ERROR %0t: tick missing", $time);
      test_done();
    end
  endtask

  task automatic wdog();
    @(posedge clk);
    wdog_rst <= 1'b1;
    @(posedge clk);
    wdog_rst <= 1'b0;
  endtask

  task automatic hw_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("ERROR %0t: run too long", $time);
    test_done();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    wdog_rst = 1'b0;
    osc_fast_in = 1'b0;
    osc_slow_in = 1'b0;
    avs_req = '0;
    avs_req.byteenable = 4'hf;
    mask = 32'h8000_0000;
    use_fast = 1'b0;
    ale = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped place
    rdc(`RTC_OFS_COUNT, 32'h0000_0000);
    rdc(`RTC_OFS_ALARM, 32'h0000_0000);
    rdc(`RTC_OFS_STATUS, 32'h0000_0000);
    rdc(`RTC_OFS_TRIM, 32'h0000_7fff);
    wr(5'h14, 32'hffff_ffff);
    rdc(5'h14, 32'h0000_0000);
    // trim survives watchdog, alarm, count and source select clear
    wr(`RTC_OFS_TRIM, 32'h0000_0003);
    wr(`RTC_OFS_CTRL, 32'h0000_0001);
    wr(`RTC_OFS_ALARM, 32'h0000_0055);
    rdc(`RTC_OFS_ALARM, 32'h0000_0000);
    pulse();
    rdc(`RTC_OFS_ALARM, 32'h0000_0000);
    pulse();
    rdc(`RTC_OFS_ALARM, 32'h0000_0055);
    wdog();
    rdc(`RTC_OFS_TRIM, 32'h0000_0003);
    rdc(`RTC_OFS_ALARM, 32'h0000_0000);
    rdc(`RTC_OFS_COUNT, 32'h0000_0000);
    rdc(`RTC_OFS_CTRL, 32'h0000_0000);
    wr(`RTC_OFS_CTRL, 32'h0000_0001);
    // free run, one step per divider+1 source clocks
    tick_wait(n);
    tick_wait(n);
    check(n, 4);
    rdc(`RTC_OFS_COUNT, 32'h0000_0002);
    // staged count write lands after two source clocks, then keeps counting
    wr(`RTC_OFS_COUNT, 32'hffff_fffe);
    rdc(`RTC_OFS_STATUS, 32'h0000_000a);
    pulse();
    pulse();
    rdc(`RTC_OFS_STATUS, 32'h0000_0002);
    rdc(`RTC_OFS_COUNT, 32'hffff_fffe);
    tick_wait(n);
    check(n, 2);
    rdc(`RTC_OFS_COUNT, 32'hffff_ffff);
    // alarm at the wrap: compare sees the incremented count
    ale = 1'b1;
    wr(`RTC_OFS_ALARM, 32'h0000_0000);
    tick_wait(n);
    rdc(`RTC_OFS_COUNT, 32'h0000_0000);
    rdc(`RTC_OFS_STATUS, 32'h0000_0007);
    check(pending, 32'hc000_0000);
    check({31'h0, irq}, 32'h1);
    check({31'h0, wake}, 32'h1);
    mask <= 32'h0000_0000;
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    // write one clears only the flag that was written
    wr(`RTC_OFS_STATUS, 32'h0000_0005);
    rdc(`RTC_OFS_STATUS, 32'h0000_0006);
    check({31'h0, events.alarm_irq_source}, 32'h0);
    // match without enable leaves the flag clear
    ale = 1'b0;
    wr(`RTC_OFS_ALARM, 32'h0000_0001);
    tick_wait(n);
    rdc(`RTC_OFS_COUNT, 32'h0000_0001);
    rdc(`RTC_OFS_STATUS, 32'h0000_0002);
    // fast oscillator prescaled by 112 with divider zero
    wr(`RTC_OFS_TRIM, 32'h0000_0000);
    wr(`RTC_OFS_CTRL, 32'h0000_0000);
    use_fast = 1'b1;
    tick_wait(n);
    tick_wait(n);
    check(n, 112);
    // delete count swallows one source clock every fourth tick
    use_fast = 1'b0;
    wr(`RTC_OFS_CTRL, 32'h0000_0001);
    wr(`RTC_OFS_TRIM, 32'h0001_0000);
    tick_wait(n);
    tot = 0;
    repeat (8) begin
      tick_wait(n);
      tot += n;
    end
    check(tot, 10);
    // lock freezes trim until a hardware reset
    wr(`RTC_OFS_TRIM, 32'h8000_0003);
    rdc(`RTC_OFS_TRIM, 32'h8000_0003);
    wr(`RTC_OFS_TRIM, 32'h0000_0005);
    rdc(`RTC_OFS_TRIM, 32'h8000_0003);
    wdog();
    rdc(`RTC_OFS_TRIM, 32'h8000_0003);
    hw_reset();
    rdc(`RTC_OFS_TRIM, 32'h0000_7fff);
    rdc(`RTC_OFS_COUNT, 32'h0000_0000);
    test_done();
  end
endmodule // tb_rtc_counter_alarm_trim
